// >>> bench/mecc_fault_handler_sva.sv
`timescale 1ns/1ps
`include "mecc_consts.vh"
module mecc_fault_handler_sva (
	input wire        i_sys_clk,
	input wire        i_resetn,
	input wire [15:0] i_reg_addr,
	input wire [7:0]  i_reg_wdata,
	input wire        i_reg_wr,
	input wire        i_reg_rd,
	input wire [7:0]  o_reg_rdata,
	input wire        i_sram_wr,
	input wire [15:0] i_sram_wr_addr,
	input wire [7:0]  i_sram_wr_data,
	input wire        o_sram_wr_en,
	input wire [15:0] o_sram_wr_addr,
	input wire [12:0] o_sram_wr_word,
	input wire        i_sram_rd_valid,
	input wire        o_sram_rd_valid,
	input wire        i_fetch_valid,
	input wire [15:0] i_fetch_addr,
	input wire [15:0] i_fetch_word,
	input wire        o_fetch_valid,
	input wire [7:0]  o_fetch_data,
	input wire [15:0] o_code_fault_address,
	input wire        o_soft_reset,
	input wire        o_sram_uncorr_irq,
	input wire        o_sram_corr_irq,
	input wire        o_code_uncorr_irq,
	input wire        o_code_corr_irq
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	// Nibble check code, kept apart from the design's own encoder.
	function automatic [3:0] ck4(input [3:0] d);
		ck4[2:0] = {d[1] ^ d[2] ^ d[3], d[0] ^ d[2] ^ d[3], d[0] ^ d[1] ^ d[3]};
		ck4[3] = ^{d, ck4[2:0]};
	endfunction
	// High when the fetched word carries no fault at all.
	wire code_ok = i_fetch_word[15:8] == {ck4(i_fetch_word[7:4]), ck4(i_fetch_word[3:0])};
	// A write of zero to the data flags, or to the code enables, lowers both requests of that register.
	wire dc_clr = i_reg_wr && i_reg_addr == `MECC_ADDR_DATA_CFG && i_reg_wdata[1:0] == 2'b00;
	wire cc_off = i_reg_wr && i_reg_addr == `MECC_ADDR_CODE_CFG && i_reg_wdata[5:4] == 2'b00;
	wire dc_wr  = i_reg_wr && i_reg_addr == `MECC_ADDR_DATA_CFG;

	rd_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
		else $error("read data not idle");
	fetch_clean_a: assert property (i_fetch_valid && code_ok |=> o_fetch_valid
		&& o_fetch_data == $past(i_fetch_word[7:0])) else $error("clean fetch wrong");
	sram_lat_a: assert property (i_sram_rd_valid |=> o_sram_rd_valid)
		else $error("sram read lost");
	wr_pass_a: assert property (i_sram_wr |=> o_sram_wr_en && o_sram_wr_addr ==
		$past(i_sram_wr_addr) && o_sram_wr_word[7:0] == $past(i_sram_wr_data))
		else $error("sram write word wrong");
	code_addr_a: assert property (i_fetch_valid && !code_ok |=>
		o_code_fault_address == $past(i_fetch_addr)) else $error("fault address wrong");
	soft_cause_a: assert property (o_soft_reset |-> $past(i_fetch_valid) && !$past(code_ok))
		else $error("soft reset without fault");
	sram_clr_a: assert property (dc_clr && !i_sram_rd_valid |=>
		!o_sram_corr_irq && !o_sram_uncorr_irq) else $error("sram request stuck");
	code_gate_a: assert property (cc_off |=> !o_code_corr_irq && !o_code_uncorr_irq)
		else $error("code request not gated");
	flag_hold_a: assert property (o_sram_corr_irq && !dc_wr |=> o_sram_corr_irq)
		else $error("flag cleared by hardware");

	cover property (o_soft_reset);
	cover property (o_code_uncorr_irq);
	cover property (o_sram_corr_irq && o_sram_uncorr_irq);
endmodule // mecc_fault_handler_sva

bind mecc_fault_handler mecc_fault_handler_sva u_mecc_fault_handler_sva (.*);

// >>> bench/mecc_fault_handler_tb.sv
`timescale 1ns/1ps
`include "mecc_consts.vh"
module mecc_fault_handler_tb;
	localparam DC = `MECC_ADDR_DATA_CFG;
	localparam CC = `MECC_ADDR_CODE_CFG;
	localparam AC = `MECC_ADDR_CODE_ACTION;
	localparam FL = `MECC_ADDR_DATA_FA_LOW;
	localparam FH = `MECC_ADDR_DATA_FA_HIGH;
	reg         clk, rstn, wr, rd, swr, req, fv, fcv;
	reg  [15:0] ra, swa, rqa, fa, fw;
	reg  [7:0]  wd, swd;
	reg  [12:0] flip;
	wire        wen, srv, sv, ofv, ofcv, srst, sui, sci, cui, cci;
	wire [15:0] wa, sra, ofc, cfa;
	wire [12:0] ww, srw;
	wire [7:0]  rdat, srd, ofd;
	integer     miscompares, n_checks, i;

	mecc_fault_handler u_mecc_fault_handler (.i_sys_clk(clk), .i_resetn(rstn), .i_clk_en(1'b1),
		.i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat),
		.i_sram_wr(swr), .i_sram_wr_addr(swa), .i_sram_wr_data(swd), .o_sram_wr_en(wen),
		.o_sram_wr_addr(wa), .o_sram_wr_word(ww), .i_sram_rd_valid(srv),
		.i_sram_rd_addr(sra), .i_sram_rd_word(srw), .o_sram_rd_valid(sv), .o_sram_rd_data(srd),
		.i_fetch_valid(fv), .i_fetch_addr(fa), .i_fetch_word(fw), .o_fetch_valid(ofv),
		.o_fetch_data(ofd), .i_fc_rd_valid(fcv), .i_fc_rd_word(fw), .o_fc_rd_valid(ofcv),
		.o_fc_rd_data(ofc), .o_code_fault_address(cfa), .o_soft_reset(srst),
		.o_sram_uncorr_irq(sui), .o_sram_corr_irq(sci), .o_code_uncorr_irq(cui),
		.o_code_corr_irq(cci));
	mecc_sram_model u_mecc_sram_model (.i_clk(clk), .i_wr_en(wen), .i_wr_addr(wa),
		.i_wr_word(ww), .i_rd_req(req), .i_rd_addr(rqa), .i_flip(flip), .o_rd_valid(srv),
		.o_rd_addr(sra), .o_rd_word(srw));

	// Clock of 100 ns and a watchdog that ends a hung run as a failure.
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares = miscompares + 1;
		stop_test;
	end
	// Nibble check code and a full fault-free code word.
	function [3:0] ck4(input [3:0] d);
		ck4[2:0] = {d[1] ^ d[2] ^ d[3], d[0] ^ d[2] ^ d[3], d[0] ^ d[1] ^ d[3]};
		ck4[3] = ^{d, ck4[2:0]};
	endfunction
	function [15:0] cw(input [7:0] d);
		cw = {ck4(d[7:4]), ck4(d[3:0]), d};
	endfunction
	task chk(input string nm, input [15:0] e, input [15:0] g);
		n_checks = n_checks + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("unexpected %0s: expected %h seen %h", nm, e, g);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Register port cycles: one-cycle strobes, read data in the following cycle.
	task wreg(input [15:0] a, input [7:0] d);
		@(posedge clk);
		wr <= 1;
		ra <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
	endtask
	task rreg(input [15:0] a, input [7:0] e);
		@(posedge clk);
		rd <= 1;
		ra <= a;
		@(posedge clk);
		rd <= 0;
		#1 chk("register", e, rdat);
	endtask
	// CPU side SRAM write, and a read through the array model with flipped bits.
	task swrite(input [15:0] a, input [7:0] d);
		@(posedge clk);
		swr <= 1;
		swa <= a;
		swd <= d;
		@(posedge clk);
		swr <= 0;
	endtask
	task sread(input [15:0] a, input [12:0] f, input cd, input [7:0] e);
		@(posedge clk);
		req <= 1;
		rqa <= a;
		flip <= f;
		@(posedge clk);
		req <= 0;
		@(posedge clk);
		#1 chk("sram valid", 1, sv);
		if (cd)
			chk("sram data", e, srd);
	endtask
	// One fetch (c low) or one flash controller read (c high).
	task code(input c, input [15:0] a, input [15:0] w);
		@(posedge clk);
		fv <= !c;
		fcv <= c;
		fa <= a;
		fw <= w;
		@(posedge clk);
		fv <= 0;
		fcv <= 0;
		fw <= ~w;
		#1;
	endtask

	initial begin
		{rstn, wr, rd, swr, req, fv, fcv} = 0;
		{ra, wd, swa, swd, rqa, flip, fa, fw} = 0;
		miscompares = 0;
		n_checks = 0;
		repeat (8) @(posedge clk);
		rstn <= 1;
		rreg(CC, 8'h80);
		rreg(DC, 8'h80);
		rreg(FL, 8'h00);
		rreg(FH, 8'h80);
		rreg(AC, 8'h00);
		rreg(16'hA011, 8'h00);
		$display("test reset values done");
		swrite(16'h0012, 8'h5A);
		swrite(16'h0034, 8'hC3);
		sread(16'h0012, 13'h0000, 1, 8'h5A);
		rreg(DC, 8'h80);
		sread(16'h0012, 13'h0008, 1, 8'h5A);
		rreg(DC, 8'h81);
		wreg(FL, 8'hFF);
		rreg(FL, 8'h12);
		rreg(FH, 8'h00);
		sread(16'h0034, 13'h0011, 0, 8'h00);
		rreg(DC, 8'h83);
		rreg(FL, 8'h12);
		wreg(DC, 8'hB3);
		#1 chk("sram irqs", 2'b11, {sui, sci});
		rreg(DC, 8'hB3);
		wreg(DC, 8'hB2);
		#1 chk("sram irqs", 2'b10, {sui, sci});
		wreg(DC, 8'hB0);
		sread(16'h0034, 13'h1000, 1, 8'hC3);
		chk("sram corr irq", 1, sci);
		rreg(FL, 8'h34);
		swrite(16'h0034, 8'hC3);
		wreg(DC, 8'hB0);
		sread(16'h0034, 13'h0000, 1, 8'hC3);
		rreg(DC, 8'hB0);
		wreg(DC, 8'h00);
		swrite(16'h0056, 8'hA5);
		#1 chk("check bits", 5'h00, ww[12:8]);
		sread(16'h0056, 13'h0001, 1, 8'hA4);
		rreg(DC, 8'h00);
		wreg(DC, 8'h80);
		$display("test sram done");
		code(0, 16'h1234, cw(8'hC3));
		chk("fetch data", 8'hC3, ofd);
		rreg(CC, 8'h80);
		for (i = 0; i < 16; i = i + 1) begin
			code(0, 16'h2000 + i, cw(8'h96) ^ (16'h0001 << i));
			chk("fetch data", 8'h96, ofd);
			chk("fetch valid", 1, ofv);
			chk("fault address", 16'h2000 + i, cfa);
			rreg(CC, 8'h81);
		end
		wreg(CC, 8'hB0);
		code(0, 16'h3456, cw(8'h96) ^ 16'h0003);
		chk("code uncorr irq", 1, cui);
		chk("fault address", 16'h3456, cfa);
		rreg(CC, 8'hB2);
		code(0, 16'h3457, cw(8'h96) ^ 16'h0100);
		chk("fetch data", 8'h96, ofd);
		chk("code corr irq", 1, cci);
		wreg(AC, 8'h01);
		rreg(AC, 8'h01);
		wreg(CC, 8'hB0);
		code(0, 16'h4000, cw(8'h96) ^ 16'h0030);
		chk("soft reset", 2'b10, {srst, cui});
		rreg(CC, 8'hB2);
		wreg(AC, 8'h00);
		code(1, 16'h0000, cw(8'h5C) ^ 16'h0001);
		chk("flash read", cw(8'h5C), ofc);
		wreg(CC, 8'h00);
		code(1, 16'h0000, cw(8'h5C) ^ 16'h0001);
		chk("flash raw", cw(8'h5C) ^ 16'h0001, ofc);
		chk("flash valid", 1, ofcv);
		$display("test code done");
		stop_test;
	end
endmodule // mecc_fault_handler_tb

// >>> bench/mecc_sram_model.sv
`timescale 1ns/1ps
module mecc_sram_model (
	input  wire        i_clk,
	input  wire        i_wr_en,
	input  wire [15:0] i_wr_addr,
	input  wire [12:0] i_wr_word,
	input  wire        i_rd_req,
	input  wire [15:0] i_rd_addr,
	input  wire [12:0] i_flip,
	output reg         o_rd_valid,
	output reg  [15:0] o_rd_addr,
	output reg  [12:0] o_rd_word
);
	reg [12:0] mem_ff [0:255];
	// Stores whole 13-bit words; a read flips the chosen bits. When idle the word
	// lines show the inverse of the last value so nothing stale looks valid.
	always @(posedge i_clk) begin
		if (i_wr_en)
			mem_ff[i_wr_addr[7:0]] <= i_wr_word;
		o_rd_valid <= i_rd_req;
		o_rd_addr <= i_rd_addr;
		o_rd_word <= i_rd_req ? mem_ff[i_rd_addr[7:0]] ^ i_flip : ~o_rd_word;
	end
endmodule // mecc_sram_model

// >>> src/mecc_consts.vh
`ifndef MECC_CONSTS_VH
`define MECC_CONSTS_VH

// Register addresses on the 16-bit register port.
`define MECC_ADDR_CODE_CFG      16'hA00D
`define MECC_ADDR_CODE_ACTION   16'hA010
`define MECC_ADDR_DATA_CFG      16'hA02D
`define MECC_ADDR_DATA_FA_LOW   16'hA02E
`define MECC_ADDR_DATA_FA_HIGH  16'hA02F

// Reset values.
`define MECC_RST_CODE_CFG       8'h80
`define MECC_RST_DATA_CFG       8'h80
`define MECC_RST_CODE_ACTION    8'h00
`define MECC_RST_FA_LOW         8'h00
`define MECC_RST_FA_HIGH        8'h80
`define MECC_RST_CODE_FA        16'h0000

// Field positions shared by both configuration registers.
`define MECC_BIT_ENABLE         7
`define MECC_BIT_UNCORR_IEN     5
`define MECC_BIT_CORR_IEN       4
`define MECC_BIT_UNCORR_FLAG    1
`define MECC_BIT_CORR_FLAG      0

// Field position in the code action register.
`define MECC_BIT_RESET_ON_UNCORR 0

// Readable bits of each register; all others read as zero.
`define MECC_CFG_READ_MASK      8'hB3
`define MECC_ACTION_READ_MASK   8'h01

// Word layouts.
`define MECC_SRAM_WORD_W        13
`define MECC_CODE_WORD_W        16

`endif

// >>> src/mecc_fault_handler.v
// Contract
// R1 - Data config bit 7 enables SRAM checking and resets set (0x80).
// R2 - Data config: uncorrectable enable bit 5, correctable bit 4, flags bits 1, 0.
// R3 - A correctable SRAM read fault sets the data correctable flag.
// R4 - Data flags set regardless of enables; only interrupts are gated.
// R5 - Hardware never clears error flags; only software does.
// R6 - Correctable SRAM read faults return corrected data to the reader.
// R7 - Software should rewrite corrected data into SRAM after the interrupt.
// R8 - SRAM fault address latched into read-only low and high registers.
// R9 - While a data flag is set, later faults keep the latched address.
// R10 - Code word is 16 bits: low byte instruction, high byte check bits.
// R11 - Check bits 15:12 protect data 7:4, bits 11:8 protect data 3:0.
// R12 - Each nibble code corrects single and detects double bit errors.
// R13 - Code checking runs on every fetch in hardware.
// R14 - Correctable fetch errors deliver corrected byte; optional interrupt.
// R15 - Uncorrectable fetch error raises interrupt or software reset, per setting.
// R16 - Faulting fetch address latched into 16-bit code fault address.
// R17 - Code config bit 7 selects corrected or raw flash controller low byte.
// R18 - Uncorrectable fetch error sets code flag bit 1 regardless of enable.
// R19 - Correctable fetch error sets code flag bit 0 regardless of enable.
// R20 - SRAM word holds 8 data and 5 check bits, single fix, double detect.
// R21 - Toggling SRAM checking corrupts contents; software reinitialises SRAM.
// R22 - Each interrupt is high while its flag and enable are both set; the code uncorrectable one is held low while reset mode is on.
// R23 - Writing zero clears a flag; writing one leaves it unchanged.
`timescale 1ns/1ps
`include "mecc_consts.vh"

module mecc_fault_handler (
	input  wire        i_sys_clk,
	input  wire        i_resetn,
	input  wire        i_clk_en,
	// Register port.
	input  wire [15:0] i_reg_addr,
	input  wire [7:0]  i_reg_wdata,
	input  wire        i_reg_wr,
	input  wire        i_reg_rd,
	output reg  [7:0]  o_reg_rdata,
	// CPU writes to data SRAM.
	input  wire        i_sram_wr,
	input  wire [15:0] i_sram_wr_addr,
	input  wire [7:0]  i_sram_wr_data,
	output reg         o_sram_wr_en,
	output reg  [15:0] o_sram_wr_addr,
	output reg  [12:0] o_sram_wr_word,
	// CPU reads from data SRAM.
	input  wire        i_sram_rd_valid,
	input  wire [15:0] i_sram_rd_addr,
	input  wire [12:0] i_sram_rd_word,
	output reg         o_sram_rd_valid,
	output reg  [7:0]  o_sram_rd_data,
	// Instruction fetch path.
	input  wire        i_fetch_valid,
	input  wire [15:0] i_fetch_addr,
	input  wire [15:0] i_fetch_word,
	output reg         o_fetch_valid,
	output reg  [7:0]  o_fetch_data,
	// Flash controller read path.
	input  wire        i_fc_rd_valid,
	input  wire [15:0] i_fc_rd_word,
	output reg         o_fc_rd_valid,
	output reg  [15:0] o_fc_rd_data,
	// Fault reporting.
	output reg  [15:0] o_code_fault_address,
	output reg         o_soft_reset,
	output wire        o_sram_uncorr_irq,
	output wire        o_sram_corr_irq,
	output wire        o_code_uncorr_irq,
	output wire        o_code_corr_irq
);

	// Encodes one SRAM byte as Hamming parity in 11:8 and overall parity in 12.
	function [12:0] mecc_sram_encode;
		input [7:0] d;
		reg   [3:0] p;
		begin
			p[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
			p[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
			p[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
			p[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
			mecc_sram_encode = {(^d) ^ (^p), p, d};
		end
	endfunction

	// Decodes an SRAM word: returns uncorrectable, corrected and the data byte.
	function [9:0] mecc_sram_decode;
		input [12:0] w;
		reg   [12:0] e;
		reg   [3:0]  s;
		reg   [7:0]  d;
		reg          ov;
		reg          unc;
		reg          cor;
		begin
			// Recompute the check bits from the data and compare with those stored.
			e = mecc_sram_encode(w[7:0]);
			s = e[11:8] ^ w[11:8];
			ov  = ^w;
			d   = w[7:0];
			unc = 1'b0;
			cor = 1'b0;
			if (ov) begin
				// A single flip: the syndrome names the bit position.
				cor = 1'b1;
				case (s)
					4'h3: d[0] = ~d[0];
					4'h5: d[1] = ~d[1];
					4'h6: d[2] = ~d[2];
					4'h7: d[3] = ~d[3];
					4'h9: d[4] = ~d[4];
					4'hA: d[5] = ~d[5];
					4'hB: d[6] = ~d[6];
					4'hC: d[7] = ~d[7];
					4'h0, 4'h1, 4'h2, 4'h4, 4'h8: d = w[7:0];
					default: begin
						cor = 1'b0;
						unc = 1'b1;
					end
				endcase
			end else if (s != 4'h0) begin
				unc = 1'b1;
			end
			mecc_sram_decode = {unc, cor, d};
		end
	endfunction

	// Hamming parity of one code nibble, with overall parity in bit 3.
	function [3:0] mecc_nib_encode;
		input [3:0] d;
		reg   [2:0] p;
		begin
			p[0] = d[0] ^ d[1] ^ d[3];
			p[1] = d[0] ^ d[2] ^ d[3];
			p[2] = d[1] ^ d[2] ^ d[3];
			mecc_nib_encode = {(^d) ^ (^p), p};
		end
	endfunction

	// Decodes one nibble against its four check bits.
	function [5:0] mecc_nib_decode;
		input [3:0] d_in;
		input [3:0] c;
		reg   [3:0] e;
		reg   [2:0] s;
		reg   [3:0] d;
		reg         ov;
		reg         unc;
		reg         cor;
		begin
			e   = mecc_nib_encode(d_in);
			s   = e[2:0] ^ c[2:0];
			ov  = (^d_in) ^ (^c);
			d   = d_in;
			unc = 1'b0;
			cor = 1'b0;
			if (ov) begin
				cor = 1'b1;
				case (s)
					3'h3: d[0] = ~d[0];
					3'h5: d[1] = ~d[1];
					3'h6: d[2] = ~d[2];
					3'h7: d[3] = ~d[3];
					default: d = d_in;
				endcase
			end else if (s != 3'h0) begin
				unc = 1'b1;
			end
			mecc_nib_decode = {unc, cor, d};
		end
	endfunction

	// Configuration and status registers.
	reg  [7:0]  data_cfg_ff;
	reg  [7:0]  code_cfg_ff;
	reg  [7:0]  code_action_ff;
	reg  [15:0] sram_fault_address_ff;
	reg  [7:0]  nxt_data_cfg;
	reg  [7:0]  nxt_code_cfg;

	wire sram_check_enable         = data_cfg_ff[`MECC_BIT_ENABLE]; // R1
	wire sram_uncorr_irq_enable    = data_cfg_ff[`MECC_BIT_UNCORR_IEN];
	wire sram_corr_irq_enable      = data_cfg_ff[`MECC_BIT_CORR_IEN];
	wire sram_uncorr_flag          = data_cfg_ff[`MECC_BIT_UNCORR_FLAG];
	wire sram_corr_flag            = data_cfg_ff[`MECC_BIT_CORR_FLAG];
	wire flash_read_correct_select = code_cfg_ff[`MECC_BIT_ENABLE];
	wire code_uncorr_irq_enable    = code_cfg_ff[`MECC_BIT_UNCORR_IEN];
	wire code_corr_irq_enable      = code_cfg_ff[`MECC_BIT_CORR_IEN];
	wire code_uncorr_flag          = code_cfg_ff[`MECC_BIT_UNCORR_FLAG];
	wire code_corr_flag            = code_cfg_ff[`MECC_BIT_CORR_FLAG];
	wire reset_on_uncorr           = code_action_ff[`MECC_BIT_RESET_ON_UNCORR];
	wire sram_error_flag           = sram_uncorr_flag | sram_corr_flag;

	// SRAM read checking; a disabled checker passes raw data with no flags.
	wire [9:0] sram_dec     = mecc_sram_decode(i_sram_rd_word); // R20
	wire       sram_chk     = i_sram_rd_valid & sram_check_enable;
	wire       sram_unc_evt = sram_chk & sram_dec[9];
	wire       sram_cor_evt = sram_chk & sram_dec[8]; // R3

	// Fetch checking on each nibble of the instruction byte.
	wire [5:0] fetch_hi = mecc_nib_decode(i_fetch_word[7:4], i_fetch_word[15:12]); // R11
	wire [5:0] fetch_lo = mecc_nib_decode(i_fetch_word[3:0], i_fetch_word[11:8]); // R11
	wire       fetch_unc = fetch_hi[5] | fetch_lo[5]; // R12
	wire       fetch_cor = (fetch_hi[4] | fetch_lo[4]) & ~fetch_unc; // R12
	wire       code_unc_evt = i_fetch_valid & fetch_unc; // R13
	wire       code_cor_evt = i_fetch_valid & fetch_cor; // R13

	// Flash controller reads use the same nibble decoders.
	wire [5:0] fc_hi = mecc_nib_decode(i_fc_rd_word[7:4], i_fc_rd_word[15:12]);
	wire [5:0] fc_lo = mecc_nib_decode(i_fc_rd_word[3:0], i_fc_rd_word[11:8]);

	// Register decode.
	wire wr_data_cfg = i_reg_wr & (i_reg_addr == `MECC_ADDR_DATA_CFG);
	wire wr_code_cfg = i_reg_wr & (i_reg_addr == `MECC_ADDR_CODE_CFG);
	wire wr_action   = i_reg_wr & (i_reg_addr == `MECC_ADDR_CODE_ACTION);

	// Next data configuration: software writes enables, clears flags with zero,
	// and a hardware event in the same cycle wins over the clear.
	always @* begin
		nxt_data_cfg = data_cfg_ff;
		if (wr_data_cfg) begin
			nxt_data_cfg[`MECC_BIT_ENABLE]      = i_reg_wdata[`MECC_BIT_ENABLE]; // R1
			nxt_data_cfg[`MECC_BIT_UNCORR_IEN]  = i_reg_wdata[`MECC_BIT_UNCORR_IEN]; // R2
			nxt_data_cfg[`MECC_BIT_CORR_IEN]    = i_reg_wdata[`MECC_BIT_CORR_IEN]; // R2
			nxt_data_cfg[`MECC_BIT_UNCORR_FLAG] = sram_uncorr_flag &
				i_reg_wdata[`MECC_BIT_UNCORR_FLAG]; // R23
			nxt_data_cfg[`MECC_BIT_CORR_FLAG]   = sram_corr_flag &
				i_reg_wdata[`MECC_BIT_CORR_FLAG]; // R23
		end
		if (sram_unc_evt) begin
			nxt_data_cfg[`MECC_BIT_UNCORR_FLAG] = 1'b1; // R4
		end
		if (sram_cor_evt) begin
			nxt_data_cfg[`MECC_BIT_CORR_FLAG] = 1'b1; // R3
		end
		nxt_data_cfg = nxt_data_cfg & `MECC_CFG_READ_MASK;
	end

	// Next code configuration, built the same way as the data one.
	always @* begin
		nxt_code_cfg = code_cfg_ff;
		if (wr_code_cfg) begin
			nxt_code_cfg[`MECC_BIT_ENABLE]      = i_reg_wdata[`MECC_BIT_ENABLE]; // R17
			nxt_code_cfg[`MECC_BIT_UNCORR_IEN]  = i_reg_wdata[`MECC_BIT_UNCORR_IEN];
			nxt_code_cfg[`MECC_BIT_CORR_IEN]    = i_reg_wdata[`MECC_BIT_CORR_IEN];
			nxt_code_cfg[`MECC_BIT_UNCORR_FLAG] = code_uncorr_flag &
				i_reg_wdata[`MECC_BIT_UNCORR_FLAG]; // R23
			nxt_code_cfg[`MECC_BIT_CORR_FLAG]   = code_corr_flag &
				i_reg_wdata[`MECC_BIT_CORR_FLAG]; // R23
		end
		if (code_unc_evt) begin
			nxt_code_cfg[`MECC_BIT_UNCORR_FLAG] = 1'b1; // R18
		end
		if (code_cor_evt) begin
			nxt_code_cfg[`MECC_BIT_CORR_FLAG] = 1'b1; // R19
		end
		nxt_code_cfg = nxt_code_cfg & `MECC_CFG_READ_MASK;
	end

	// Configuration registers; no hardware path ever clears a flag.
	always @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			data_cfg_ff    <= `MECC_RST_DATA_CFG; // R1
			code_cfg_ff    <= `MECC_RST_CODE_CFG;
			code_action_ff <= `MECC_RST_CODE_ACTION;
		end else if (i_clk_en) begin
			data_cfg_ff <= nxt_data_cfg; // R5
			code_cfg_ff <= nxt_code_cfg; // R5
			if (wr_action) begin
				code_action_ff <= i_reg_wdata & `MECC_ACTION_READ_MASK;
			end
		end
	end

	// SRAM fault address: held while any data flag stays set.
	always @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			sram_fault_address_ff <= {`MECC_RST_FA_HIGH, `MECC_RST_FA_LOW};
		end else if (i_clk_en) begin
			if ((sram_unc_evt | sram_cor_evt) & ~sram_error_flag) begin // R9
				sram_fault_address_ff <= i_sram_rd_addr; // R8
			end
		end
	end

	// Code fault address follows the most recent faulting fetch.
	always @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_code_fault_address <= `MECC_RST_CODE_FA;
		end else if (i_clk_en) begin
			if (code_unc_evt | code_cor_evt) begin
				o_code_fault_address <= i_fetch_addr; // R16
			end
		end
	end

	// Register read data stands one cycle after the strobe, zero otherwise.
	always @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_reg_rdata <= 8'h00;
		end else if (i_clk_en) begin
			o_reg_rdata <= 8'h00;
			if (i_reg_rd) begin
				case (i_reg_addr)
					`MECC_ADDR_DATA_CFG:    o_reg_rdata <= data_cfg_ff;
					`MECC_ADDR_CODE_CFG:    o_reg_rdata <= code_cfg_ff;
					`MECC_ADDR_CODE_ACTION: o_reg_rdata <= code_action_ff;
					`MECC_ADDR_DATA_FA_LOW: o_reg_rdata <= sram_fault_address_ff[7:0]; // R8
					`MECC_ADDR_DATA_FA_HIGH: o_reg_rdata <= sram_fault_address_ff[15:8]; // R8
					default:                o_reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// SRAM write path: check bits are stored only while checking is on, so
	// flipping the mode leaves an old word inconsistent until rewritten unless its byte encodes to all-zero check bits.
	always @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_sram_wr_en   <= 1'b0;
			o_sram_wr_addr <= 16'h0000;
			o_sram_wr_word <= 13'h0000;
		end else if (i_clk_en) begin
			o_sram_wr_en   <= i_sram_wr;
			o_sram_wr_addr <= i_sram_wr_addr;
			if (sram_check_enable) begin
				o_sram_wr_word <= mecc_sram_encode(i_sram_wr_data); // R20
			end else begin
				o_sram_wr_word <= {5'h00, i_sram_wr_data}; // R21
			end
		end
	end

	// SRAM read return: corrected byte when checking is on.
	always @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_sram_rd_valid <= 1'b0;
			o_sram_rd_data  <= 8'h00;
		end else if (i_clk_en) begin
			o_sram_rd_valid <= i_sram_rd_valid;
			if (i_sram_rd_valid) begin
				if (sram_check_enable) begin
					o_sram_rd_data <= sram_dec[7:0]; // R6
				end else begin
					o_sram_rd_data <= i_sram_rd_word[7:0];
				end
			end
		end
	end

	// Fetch return: instruction byte from the low half, corrected per nibble.
	always @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_fetch_valid <= 1'b0;
			o_fetch_data  <= 8'h00;
		end else if (i_clk_en) begin
			o_fetch_valid <= i_fetch_valid;
			if (i_fetch_valid) begin
				o_fetch_data <= {fetch_hi[3:0], fetch_lo[3:0]}; // R10 R14
			end
		end
	end

	// Flash controller return: high byte raw, low byte as selected.
	always @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_fc_rd_valid <= 1'b0;
			o_fc_rd_data  <= 16'h0000;
		end else if (i_clk_en) begin
			o_fc_rd_valid <= i_fc_rd_valid;
			if (i_fc_rd_valid) begin
				if (flash_read_correct_select) begin
					o_fc_rd_data <= {i_fc_rd_word[15:8], fc_hi[3:0], fc_lo[3:0]}; // R17
				end else begin
					o_fc_rd_data <= i_fc_rd_word; // R17
				end
			end
		end
	end

	// One-cycle software reset request for uncorrectable fetches in reset mode.
	always @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			o_soft_reset <= 1'b0;
		end else if (i_clk_en) begin
			o_soft_reset <= code_unc_evt & reset_on_uncorr; // R15
		end
	end

	// Interrupt levels: flag and enable; reset mode replaces the code
	// uncorrectable interrupt.
	assign o_sram_uncorr_irq = sram_uncorr_flag & sram_uncorr_irq_enable; // R22
	assign o_sram_corr_irq   = sram_corr_flag & sram_corr_irq_enable; // R22
	assign o_code_uncorr_irq = code_uncorr_flag & code_uncorr_irq_enable &
		~reset_on_uncorr; // R15
	assign o_code_corr_irq   = code_corr_flag & code_corr_irq_enable; // R14

endmodule // mecc_fault_handler
